// file: cmc_pkg.sv
// Purpose: constants, field layouts and carriers for the configurable macrocell block
// Assumes: word-addressed register port, 32-bit data
// Notes: term masks are split into a low word and a high word of four bits
package cmc_pkg;
  localparam int NUM_MC = 16;
  localparam int NUM_IN = 36;
  localparam int PAL_PER_MC = 5;
  localparam int PLA_TERMS = 32;
  localparam int NUM_CT = 6;
  localparam int NUM_TERMS = 128;
  localparam int TERM_IDX_W = 7;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int HI_W = NUM_IN - DATA_W;
  // term index map
  localparam int PAL_BASE = 0;
  localparam int PLA_BASE = 80;
  localparam int CT_BASE = 112;
  // word offsets
  localparam logic [ADDR_W-1:0] ADDR_TERM_END = 10'h100;
  localparam logic [ADDR_W-1:0] ADDR_MC_CFG = 10'h100;
  localparam logic [ADDR_W-1:0] ADDR_PLA_OR = 10'h110;
  localparam logic [ADDR_W-1:0] ADDR_CT_TYPE = 10'h120;
  localparam logic [ADDR_W-1:0] ADDR_GLB = 10'h121;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 10'h122;
  localparam logic [ADDR_W-1:0] ADDR_PAD_FB = 10'h123;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 10'h124;
  // macrocell modes
  localparam logic [1:0] MODE_D = 2'h0;
  localparam logic [1:0] MODE_T = 2'h1;
  localparam logic [1:0] MODE_COMB = 2'h2;
  // clock sources
  localparam logic [1:0] CLK_SEL_GA = 2'h0;
  localparam logic [1:0] CLK_SEL_GB = 2'h1;
  localparam logic [1:0] CLK_SEL_CT3 = 2'h2;
  localparam logic [1:0] CLK_SEL_CT4 = 2'h3;
  // output enable sources: 0..3 pick control terms three to six
  localparam logic [2:0] OE_SEL_ON = 3'h4;
  localparam logic [2:0] OE_SEL_OFF = 3'h5;
  localparam int MC_CFG_W = 9;
  localparam int GLB_W = 6;

  typedef struct packed {
    logic [2:0] oe_sel;
    logic pr_dis;
    logic clk_fall;
    logic [1:0] clk_sel;
    logic [1:0] mode;
  } cmc_mc_cfg_t;

  typedef struct packed {
    logic [3:0] gb_src;
    logic gb_async;
    logic float_en;
  } cmc_glb_t;

  typedef struct packed {
    logic ga_rise;
    logic ga_fall;
    logic gb_rise;
    logic gb_fall;
    logic ct3_rise;
    logic ct4_rise;
  } cmc_clk_ev_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cmc_req_t;

  // safe after reset: D mode, first global clock, buffer floating
  localparam cmc_mc_cfg_t MC_CFG_RST = '{oe_sel: OE_SEL_OFF, pr_dis: 1'b0,
    clk_fall: 1'b0, clk_sel: CLK_SEL_GA, mode: MODE_D};
  localparam cmc_glb_t GLB_RST = '{gb_src: 4'h0, gb_async: 1'b0, float_en: 1'b0};
endpackage

// file: cmc_macrocell.sv
// Purpose: one macrocell: storage element, clock pick, preset/reset, buffer enable
// Assumes: clock sources arrive as one-cycle edge events on clk_in
// Notes: preset and reset act in the clk_in domain, reset winning over preset
`timescale 1ns/10ps
module cmc_macrocell (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire cmc_pkg::cmc_mc_cfg_t cfg_in,
  input wire cmc_pkg::cmc_clk_ev_t ev_in,
  input wire logic logic_in,
  input wire logic preset_in,
  input wire logic reset_in,
  input wire logic [3:0] oe_term_in,
  input wire logic float_off_in,
  output logic state_out,
  output logic result_out,
  output logic pad_out,
  output logic pad_oe_out
);
  import cmc_pkg::*;
  logic state_reg;
  logic state_next;
  logic sel_ev;
  logic stores;

  always_comb begin
    case (cfg_in.clk_sel)
      CLK_SEL_GA: sel_ev = cfg_in.clk_fall ? ev_in.ga_fall : ev_in.ga_rise;
      CLK_SEL_GB: sel_ev = cfg_in.clk_fall ? ev_in.gb_fall : ev_in.gb_rise;
      CLK_SEL_CT3: sel_ev = ev_in.ct3_rise;
      CLK_SEL_CT4: sel_ev = ev_in.ct4_rise;
      default: sel_ev = 1'b0;
    endcase
  end

  assign stores = (cfg_in.mode == MODE_D) || (cfg_in.mode == MODE_T);

  always_comb begin
    state_next = state_reg;
    if (sel_ev) begin
      if (cfg_in.mode == MODE_D) begin
        state_next = logic_in;
      end else if (cfg_in.mode == MODE_T && logic_in) begin
        state_next = ~state_reg;
      end
    end
    if (!cfg_in.pr_dis && preset_in) begin
      state_next = 1'b1;
    end
    if (!cfg_in.pr_dis && reset_in) begin
      state_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // combinatorial mode bypasses storage entirely
  assign result_out = stores ? state_reg : logic_in;
  assign state_out = state_reg;
  assign pad_out = result_out;

  always_comb begin
    case (cfg_in.oe_sel)
      3'h0, 3'h1, 3'h2, 3'h3: pad_oe_out = oe_term_in[cfg_in.oe_sel[1:0]];
      OE_SEL_ON: pad_oe_out = 1'b1;
      default: pad_oe_out = 1'b0;
    endcase
    if (float_off_in) begin
      pad_oe_out = 1'b0;
    end
  end

  sequence s_quiet;
    cfg_in.pr_dis || (!preset_in && !reset_in);
  endsequence

  a_d_capture: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sel_ev && cfg_in.mode == MODE_D) and s_quiet |=> state_reg == $past(logic_in))
    else $error("d mode did not capture input");
  a_t_toggle: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sel_ev && cfg_in.mode == MODE_T && logic_in) and s_quiet |=> state_reg != $past(state_reg))
    else $error("t mode did not toggle");
  a_t_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cfg_in.mode == MODE_T && !logic_in) and s_quiet |=> $stable(state_reg))
    else $error("t mode changed with low input");
  a_comb_path: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cfg_in.mode == MODE_COMB |-> result_out == logic_in)
    else $error("combinatorial path not transparent");
  a_reset_wins: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !cfg_in.pr_dis && reset_in |=> !state_reg)
    else $error("control term reset ignored");
  a_preset_sets: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !cfg_in.pr_dis && preset_in && !reset_in |=> state_reg)
    else $error("control term preset ignored");
  a_prdis_ignore: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cfg_in.pr_dis && !sel_ev |=> $stable(state_reg))
    else $error("disabled preset or reset still acted");
  a_oe_select: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !float_off_in && cfg_in.oe_sel < OE_SEL_ON |-> pad_oe_out == oe_term_in[cfg_in.oe_sel[1:0]])
    else $error("wrong enable term selected");
  a_oe_fixed: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !float_off_in && cfg_in.oe_sel != 3'h7 && cfg_in.oe_sel[2] |->
    pad_oe_out == (cfg_in.oe_sel == OE_SEL_ON))
    else $error("fixed enable setting not honoured");
  a_por_zero: assert property (@(posedge clk_in)
    $rose(rstn_in) |-> !state_reg)
    else $error("storage not zero after reset");
endmodule // cmc_macrocell

// file: cmc_logic_block.sv
// Purpose: one logic block: term arrays, six control terms, sixteen macrocells
// Assumes: all pins and the interconnect inputs are asynchronous to clk_in
// Notes: outside clocks are sampled, so they must run well below clk_in / 4
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// Overview of operation
// - macrocell works as D storage, T toggle or plain combinatorial path.
// - storage clock is one of two global clocks or two control terms.
// - second global clock comes from a pin or from a macrocell result.
// - each macrocell picks rising or falling edge of either global clock.
// - clocking control terms are AND or OR of the 36 block inputs.
// - six control terms; first two give preset and reset.
// - reset leaves every macrocell storage element at zero.
// - preset and reset can be disabled per macrocell.
// - buffer enable picks control term three, four, five or six.
// - buffer may instead be always driving or always floating.
// - float pin low with float enabled tristates every output.
// - macrocell result and pad level both return to the interconnect.
// - input pins float the buffer; pad and buried logic both feed back.
// - sixteen macrocells share control terms and term arrays.
// - each macrocell ORs five dedicated AND terms.
// - pool of 32 AND terms shared to any macrocell via OR mask.
module cmc_logic_block (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire cmc_pkg::cmc_req_t req_in,
  output logic [cmc_pkg::DATA_W-1:0] rdata_out,
  input wire logic [cmc_pkg::NUM_IN-1:0] interconnect_array_in,
  input wire logic global_sync_clock_a_in,
  input wire logic global_clock_b_in,
  input wire logic global_float_pin_n_in,
  input wire logic [cmc_pkg::NUM_MC-1:0] pad_in,
  output logic [cmc_pkg::NUM_MC-1:0] pad_out,
  output logic [cmc_pkg::NUM_MC-1:0] pad_oe_out,
  output logic [cmc_pkg::NUM_MC-1:0] macrocell_fb_out,
  output logic [cmc_pkg::NUM_MC-1:0] pad_fb_out
);
  import cmc_pkg::*;

  // configuration store
  logic [DATA_W-1:0] term_lo_reg [NUM_TERMS];
  logic [HI_W-1:0] term_hi_reg [NUM_TERMS];
  cmc_mc_cfg_t mc_cfg_reg [NUM_MC];
  logic [PLA_TERMS-1:0] pla_or_reg [NUM_MC];
  logic [NUM_CT-1:0] ct_type_reg;
  cmc_glb_t glb_reg;
  logic [DATA_W-1:0] rdata_next;

  // synchronisers
  logic [NUM_IN-1:0] in_s1_reg;
  logic [NUM_IN-1:0] in_s2_reg;
  logic [NUM_MC-1:0] pad_s1_reg;
  logic [NUM_MC-1:0] pad_s2_reg;
  logic ga_s1_reg;
  logic ga_s2_reg;
  logic gb_s1_reg;
  logic gb_s2_reg;
  logic flt_s1_reg;
  logic flt_s2_reg;
  logic ga_prev_reg;
  logic gb_prev_reg;
  logic [1:0] ctclk_prev_reg;

  logic [NUM_IN-1:0] mask [NUM_TERMS];
  logic [NUM_TERMS-1:0] term_val;
  logic [NUM_CT-1:0] ct_val;
  logic [PLA_TERMS-1:0] pla_vec;
  logic [NUM_MC-1:0] mc_logic;
  logic [NUM_MC-1:0] mc_result;
  logic [NUM_MC-1:0] mc_state;
  logic gb_level;
  logic float_off;
  cmc_clk_ev_t ev;

  logic term_hit;
  logic [TERM_IDX_W-1:0] term_idx;
  logic [3:0] mc_idx;

  assign term_hit = req_in.addr < ADDR_TERM_END;
  assign term_idx = req_in.addr[TERM_IDX_W:1];
  assign mc_idx = req_in.addr[3:0];

  // configuration writes; defaults leave every buffer floating
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int t = 0; t < NUM_TERMS; t++) begin
        term_lo_reg[t] <= '0;
        term_hi_reg[t] <= '0;
      end
      for (int m = 0; m < NUM_MC; m++) begin
        mc_cfg_reg[m] <= MC_CFG_RST;
        pla_or_reg[m] <= '0;
      end
      ct_type_reg <= '0;
      glb_reg <= GLB_RST;
    end else if (req_in.wr) begin
      if (term_hit) begin
        if (req_in.addr[0]) begin
          term_hi_reg[term_idx] <= req_in.wdata[HI_W-1:0];
        end else begin
          term_lo_reg[term_idx] <= req_in.wdata;
        end
      end else if (req_in.addr[ADDR_W-1:4] == ADDR_MC_CFG[ADDR_W-1:4]) begin
        mc_cfg_reg[mc_idx] <= cmc_mc_cfg_t'(req_in.wdata[MC_CFG_W-1:0]);
      end else if (req_in.addr[ADDR_W-1:4] == ADDR_PLA_OR[ADDR_W-1:4]) begin
        pla_or_reg[mc_idx] <= req_in.wdata[PLA_TERMS-1:0];
      end else if (req_in.addr == ADDR_CT_TYPE) begin
        ct_type_reg <= req_in.wdata[NUM_CT-1:0];
      end else if (req_in.addr == ADDR_GLB) begin
        glb_reg <= cmc_glb_t'(req_in.wdata[GLB_W-1:0]);
      end
    end
  end

  // read mux; unmapped addresses and write-only gaps read as zero
  always_comb begin
    rdata_next = '0;
    if (term_hit) begin
      if (req_in.addr[0]) begin
        rdata_next[HI_W-1:0] = term_hi_reg[term_idx];
      end else begin
        rdata_next = term_lo_reg[term_idx];
      end
    end else if (req_in.addr[ADDR_W-1:4] == ADDR_MC_CFG[ADDR_W-1:4]) begin
      rdata_next[MC_CFG_W-1:0] = mc_cfg_reg[mc_idx];
    end else if (req_in.addr[ADDR_W-1:4] == ADDR_PLA_OR[ADDR_W-1:4]) begin
      rdata_next[PLA_TERMS-1:0] = pla_or_reg[mc_idx];
    end else begin
      case (req_in.addr)
        ADDR_CT_TYPE: rdata_next[NUM_CT-1:0] = ct_type_reg;
        ADDR_GLB: rdata_next[GLB_W-1:0] = glb_reg;
        ADDR_STATE: rdata_next[NUM_MC-1:0] = mc_state;
        ADDR_PAD_FB: rdata_next[NUM_MC-1:0] = pad_s2_reg;
        ADDR_RESULT: rdata_next[NUM_MC-1:0] = mc_result;
        default: rdata_next = '0;
      endcase
    end
    if (!req_in.rd) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rdata_next;
    end
  end

  // two-stage sampling of every outside level, then edge history
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
      pad_s1_reg <= '0;
      pad_s2_reg <= '0;
      ga_s1_reg <= 1'b0;
      ga_s2_reg <= 1'b0;
      gb_s1_reg <= 1'b0;
      gb_s2_reg <= 1'b0;
      flt_s1_reg <= 1'b1;
      flt_s2_reg <= 1'b1;
      ga_prev_reg <= 1'b0;
      gb_prev_reg <= 1'b0;
      ctclk_prev_reg <= '0;
    end else begin
      in_s1_reg <= interconnect_array_in;
      in_s2_reg <= in_s1_reg;
      pad_s1_reg <= pad_in;
      pad_s2_reg <= pad_s1_reg;
      ga_s1_reg <= global_sync_clock_a_in;
      ga_s2_reg <= ga_s1_reg;
      gb_s1_reg <= global_clock_b_in;
      gb_s2_reg <= gb_s1_reg;
      flt_s1_reg <= global_float_pin_n_in;
      flt_s2_reg <= flt_s1_reg;
      ga_prev_reg <= ga_s2_reg;
      gb_prev_reg <= gb_level;
      ctclk_prev_reg <= ct_val[3:2];
    end
  end

  // an empty mask is an unprogrammed term and reads as zero
  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    assign mask[t] = {term_hi_reg[t], term_lo_reg[t]};
    assign term_val[t] = (|mask[t]) & (&(in_s2_reg | ~mask[t]));
  end

  for (genvar c = 0; c < NUM_CT; c++) begin : g_ct
    // sum form: any selected input high
    assign ct_val[c] = ct_type_reg[c] ? |(in_s2_reg & mask[CT_BASE+c])
                                      : term_val[CT_BASE+c];
  end

  assign pla_vec = term_val[PLA_BASE +: PLA_TERMS];
  // an asynchronous second clock taken from a macrocell result
  assign gb_level = glb_reg.gb_async ? mc_result[glb_reg.gb_src] : gb_s2_reg;
  assign float_off = glb_reg.float_en & ~flt_s2_reg;

  always_comb begin
    ev.ga_rise = ga_s2_reg & ~ga_prev_reg;
    ev.ga_fall = ~ga_s2_reg & ga_prev_reg;
    ev.gb_rise = gb_level & ~gb_prev_reg;
    ev.gb_fall = ~gb_level & gb_prev_reg;
    ev.ct3_rise = ct_val[2] & ~ctclk_prev_reg[0];
    ev.ct4_rise = ct_val[3] & ~ctclk_prev_reg[1];
  end

  for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
    // fast path of five dedicated terms plus any shared pool terms
    assign mc_logic[m] = (|term_val[PAL_BASE+m*PAL_PER_MC +: PAL_PER_MC])
                       | (|(pla_vec & pla_or_reg[m]));
    cmc_macrocell u_mc (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .cfg_in(mc_cfg_reg[m]),
      .ev_in(ev),
      .logic_in(mc_logic[m]),
      .preset_in(ct_val[0]),
      .reset_in(ct_val[1]),
      .oe_term_in(ct_val[5:2]),
      .float_off_in(float_off),
      .state_out(mc_state[m]),
      .result_out(mc_result[m]),
      .pad_out(pad_out[m]),
      .pad_oe_out(pad_oe_out[m])
    );
    // a floating pad must not cut the buried path: stored value or plain logic still returns
    a_mc_feedback: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !pad_oe_out[m] |-> macrocell_fb_out[m] ==
        (mc_cfg_reg[m].mode[1] ? mc_logic[m] : mc_state[m]))
      else $error("buried logic feedback lost while pad floats");
  end

  // buried result feeds back even while the pad is an input
  assign macrocell_fb_out = mc_result;
  assign pad_fb_out = pad_s2_reg;

  a_float_tristate: assert property (@(posedge clk_in) disable iff (!rstn_in)
    glb_reg.float_en && !flt_s2_reg |-> pad_oe_out == '0)
    else $error("outputs driven while float pin low");
  a_pad_feedback: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(rstn_in, 1) && $past(rstn_in, 2) |-> pad_fb_out == $past(pad_in, 2))
    else $error("pad feedback does not follow pad level");
  a_ct_sum: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ct_type_reg[2] && |(in_s2_reg & mask[CT_BASE+2]) |-> ct_val[2])
    else $error("sum form control term low with input high");
  a_gb_async: assert property (@(posedge clk_in) disable iff (!rstn_in)
    glb_reg.gb_async && $stable(glb_reg) && $rose(mc_result[glb_reg.gb_src]) |-> ev.gb_rise)
    else $error("macrocell driven clock edge missed");
  a_ga_edges: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(ga_s2_reg) |=> ev.ga_fall == 1'b0 ##0 $past(ev.ga_rise))
    else $error("global clock edge events wrong");
endmodule // cmc_logic_block

// file: cmc_pins_model.sv
// Purpose: far side of the block: pad wires and the two global clock pins
// Assumes: the bench changes every level right after a rising clk_in edge
// Notes: an undriven pad flips every cycle so a stale level can never pass
`timescale 1ns/10ps
module cmc_pins_model (
  input wire logic clk_in,
  input wire logic [15:0] drv_oe_in,
  input wire logic [15:0] drv_val_in,
  input wire logic [15:0] ext_en_in,
  input wire logic [15:0] ext_val_in,
  input wire logic ga_lvl_in,
  input wire logic gb_lvl_in,
  output logic [15:0] pad_out,
  output logic global_sync_clock_a_out,
  output logic global_clock_b_out
);
  logic [15:0] float_reg = 16'h0;
  always_ff @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end
  // the block wins a clash, the outside drive comes next, else the wire wanders
  assign pad_out = (drv_oe_in & drv_val_in) | (~drv_oe_in & ext_en_in & ext_val_in)
    | (~drv_oe_in & ~ext_en_in & float_reg);
  // first clock only ever comes from an outside oscillator level
  assign global_sync_clock_a_out = ga_lvl_in;
  assign global_clock_b_out = gb_lvl_in;
endmodule // cmc_pins_model

// file: tb.sv
// Purpose: self-checking bench for one block of configurable macrocells
// Assumes: pin changes pass the block's samplers within six clk_in cycles
// Notes: pins are changed one at a time, bar the preset and reset pair in t_prst, so data never races a clock edge
`timescale 1ns/10ps
module tb;
  import cmc_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  cmc_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_IN-1:0] ic = '0;
  logic ga = 1'b0;
  logic gb = 1'b0;
  logic flt_n = 1'b1;
  logic ga_pin, gb_pin;
  logic [NUM_MC-1:0] pad_in, pad_out, pad_oe, mfb, pfb;
  logic [NUM_MC-1:0] ext_en = '0;
  logic [NUM_MC-1:0] ext_val = '0;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 clk_in = ~clk_in;
  cmc_logic_block dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
    .interconnect_array_in(ic), .global_sync_clock_a_in(ga_pin), .global_clock_b_in(gb_pin),
    .global_float_pin_n_in(flt_n), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe),
    .macrocell_fb_out(mfb), .pad_fb_out(pfb));
  cmc_pins_model pins_u (.clk_in(clk_in), .drv_oe_in(pad_oe), .drv_val_in(pad_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .ga_lvl_in(ga), .gb_lvl_in(gb),
    .pad_out(pad_in), .global_sync_clock_a_out(ga_pin), .global_clock_b_out(gb_pin));
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  // one idle edge after each strobe keeps the strobe from being set twice at one edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req <= '0;
    @(negedge clk_in);
    d = rdata;
    @(posedge clk_in);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic term(input int t, input logic [NUM_IN-1:0] m);
    wr(ADDR_W'(2 * t), m[31:0]);
    wr(ADDR_W'(2 * t + 1), {28'h0, m[35:32]});
  endtask
  task automatic cfg(input int m, input logic [1:0] md, input logic [1:0] cs, input logic fl,
    input logic pd, input logic [2:0] oe);
    wr(ADDR_MC_CFG + ADDR_W'(m), {23'h0, oe, pd, fl, cs, md});
  endtask
  task automatic pin_ic(input int b, input logic v);
    ic[b] <= v;
    settle();
  endtask
  task automatic clk_a(input logic v);
    ga <= v;
    settle();
  endtask
  task automatic clk_b(input logic v);
    gb <= v;
    settle();
  endtask
  task automatic chk_st(input int b, input logic e);
    logic [31:0] r;
    rd(ADDR_STATE, r);
    chk_bit("state", e, r[b]);
  endtask
  task automatic t_reset;
    logic [31:0] r;
    rd(ADDR_STATE, r);
    chk("state_rst", 32'h0, r);
    rd(10'h3ff, r);
    chk("unmapped", 32'h0, r);
    wr(ADDR_STATE, 32'hffff);
    rd(ADDR_STATE, r);
    chk("state_ro", 32'h0, r);
    chk("oe_rst", 32'h0, {16'h0, pad_oe});
    $display("test reset finished");
  endtask
  task automatic t_dmode;
    term(0, 36'h1);
    cfg(0, MODE_D, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_ON);
    pin_ic(0, 1'b1);
    chk_st(0, 1'b0);
    clk_a(1'b1);
    chk_st(0, 1'b1);
    chk_bit("pad_oe0", 1'b1, pad_oe[0]);
    chk_bit("pad_out0", 1'b1, pad_out[0]);
    pin_ic(0, 1'b0);
    clk_a(1'b0);
    chk_st(0, 1'b1);
    clk_a(1'b1);
    chk_st(0, 1'b0);
    cfg(0, MODE_D, CLK_SEL_GA, 1'b1, 1'b0, OE_SEL_ON);
    pin_ic(0, 1'b1);
    clk_a(1'b0);
    chk_st(0, 1'b1);
    $display("test dmode finished");
  endtask
  task automatic t_tmode;
    term(5, 36'h2);
    cfg(1, MODE_T, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_OFF);
    pin_ic(1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      clk_a(1'b1);
      chk_st(1, ~i[0]);
      clk_a(1'b0);
    end
    pin_ic(1, 1'b0);
    clk_a(1'b1);
    chk_st(1, 1'b1);
    clk_a(1'b0);
    $display("test tmode finished");
  endtask
  task automatic t_comb;
    logic [31:0] r;
    term(10, 36'hc);
    cfg(2, MODE_COMB, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_OFF);
    pin_ic(2, 1'b1);
    chk_bit("mfb2", 1'b0, mfb[2]);
    pin_ic(3, 1'b1);
    chk_bit("mfb2", 1'b1, mfb[2]);
    rd(ADDR_RESULT, r);
    chk_bit("result2", 1'b1, r[2]);
    term(80, 36'h8_0000_0000);
    wr(ADDR_PLA_OR + 10'h3, 32'h1);
    wr(ADDR_PLA_OR + 10'h4, 32'h1);
    rd(ADDR_PLA_OR + 10'h3, r);
    chk("pla_or3", 32'h1, r);
    rd(10'h0a1, r);
    chk("term80_hi", 32'h8, r);
    rd(ADDR_MC_CFG + 10'h2, r);
    chk("mc_cfg2", 32'h142, r);
    cfg(3, MODE_COMB, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_OFF);
    cfg(4, MODE_COMB, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_OFF);
    pin_ic(35, 1'b1);
    chk("pla_on", 32'h18, {16'h0, mfb & 16'h18});
    pin_ic(35, 1'b0);
    chk("pla_off", 32'h0, {16'h0, mfb & 16'h18});
    $display("test comb finished");
  endtask
  task automatic t_ctclk;
    logic [31:0] r;
    term(25, 36'h40);
    wr(ADDR_CT_TYPE, 32'h0);
    for (int k = 0; k < 2; k++) begin
      term(114 + k, 36'h30);
      cfg(5, MODE_D, CLK_SEL_CT3 + 2'(k), 1'b0, 1'b0, OE_SEL_OFF);
      pin_ic(6, ~k[0]);
      pin_ic(4, 1'b1);
      chk_st(5, k[0]);
      pin_ic(5, 1'b1);
      chk_st(5, ~k[0]);
      pin_ic(4, 1'b0);
      pin_ic(5, 1'b0);
    end
    cfg(5, MODE_D, CLK_SEL_CT3, 1'b0, 1'b0, OE_SEL_OFF);
    wr(ADDR_CT_TYPE, 32'h4);
    rd(ADDR_CT_TYPE, r);
    chk("ct_type", 32'h4, r);
    pin_ic(6, 1'b1);
    pin_ic(4, 1'b1);
    chk_st(5, 1'b1);
    pin_ic(4, 1'b0);
    wr(ADDR_CT_TYPE, 32'h0);
    $display("test ctclk finished");
  endtask
  task automatic t_prst;
    term(112, 36'h80);
    term(113, 36'h100);
    cfg(6, MODE_D, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_OFF);
    pin_ic(7, 1'b1);
    chk_st(6, 1'b1);
    pin_ic(7, 1'b0);
    chk_st(6, 1'b1);
    pin_ic(8, 1'b1);
    chk_st(6, 1'b0);
    pin_ic(8, 1'b0);
    cfg(6, MODE_D, CLK_SEL_GA, 1'b0, 1'b1, OE_SEL_OFF);
    pin_ic(7, 1'b1);
    chk_st(6, 1'b0);
    pin_ic(7, 1'b0);
    ic[7] <= 1'b1;
    ic[8] <= 1'b1;
    settle();
    chk_st(8, 1'b0);
    ic[7] <= 1'b0;
    ic[8] <= 1'b0;
    settle();
    $display("test prst finished");
  endtask
  task automatic t_oe;
    term(35, 36'h200);
    pin_ic(9, 1'b1);
    for (int k = 0; k < 4; k++) begin
      term(114 + k, 36'h400);
      cfg(7, MODE_COMB, CLK_SEL_GA, 1'b0, 1'b0, 3'(k));
      pin_ic(10, 1'b1);
      chk_bit("oe7_on", 1'b1, pad_oe[7]);
      pin_ic(10, 1'b0);
      chk_bit("oe7_off", 1'b0, pad_oe[7]);
    end
    cfg(7, MODE_COMB, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_ON);
    chk_bit("oe7_always", 1'b1, pad_oe[7]);
    chk_bit("pad_out7", 1'b1, pad_out[7]);
    wr(ADDR_GLB, 32'h1);
    flt_n <= 1'b0;
    settle();
    chk("oe_float", 32'h0, {16'h0, pad_oe});
    flt_n <= 1'b1;
    settle();
    chk_bit("oe7_back", 1'b1, pad_oe[7]);
    wr(ADDR_GLB, 32'h0);
    flt_n <= 1'b0;
    settle();
    chk_bit("oe7_nofloat", 1'b1, pad_oe[7]);
    flt_n <= 1'b1;
    cfg(7, MODE_COMB, CLK_SEL_GA, 1'b0, 1'b0, OE_SEL_OFF);
    chk_bit("oe7_never", 1'b0, pad_oe[7]);
    $display("test oe finished");
  endtask
  task automatic t_pad;
    logic [31:0] r;
    ext_en[7] <= 1'b1;
    ext_val[7] <= 1'b0;
    settle();
    chk_bit("pfb7", 1'b0, pfb[7]);
    chk_bit("mfb7", 1'b1, mfb[7]);
    rd(ADDR_PAD_FB, r);
    chk_bit("pad_fb_reg7", 1'b0, r[7]);
    ext_val[7] <= 1'b1;
    settle();
    chk_bit("pfb7", 1'b1, pfb[7]);
    ext_en[7] <= 1'b0;
    $display("test pad finished");
  endtask
  task automatic t_gb;
    logic [31:0] r;
    term(40, 36'h800);
    cfg(8, MODE_D, CLK_SEL_GB, 1'b0, 1'b0, OE_SEL_OFF);
    pin_ic(11, 1'b1);
    clk_b(1'b1);
    chk_st(8, 1'b1);
    pin_ic(11, 1'b0);
    wr(ADDR_GLB, 32'h1e);
    rd(ADDR_GLB, r);
    chk("glb", 32'h1e, r);
    pin_ic(9, 1'b0);
    clk_b(1'b0);
    clk_b(1'b1);
    chk_st(8, 1'b1);
    pin_ic(9, 1'b1);
    chk_st(8, 1'b0);
    cfg(8, MODE_D, CLK_SEL_GB, 1'b1, 1'b0, OE_SEL_OFF);
    pin_ic(11, 1'b1);
    pin_ic(9, 1'b0);
    chk_st(8, 1'b1);
    wr(ADDR_GLB, 32'h0);
    pin_ic(11, 1'b0);
    clk_b(1'b0);
    chk_st(8, 1'b0);
    $display("test gb finished");
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_dmode();
    t_tmode();
    t_comb();
    t_ctclk();
    t_prst();
    t_oe();
    t_pad();
    t_gb();
    complete_run();
  end
endmodule // tb
